// file: hdl/standard_timer_pkg.sv
// Constants, register map and control layout of the standard timer block.
// Assumes an APB master with 32-bit data; each register is one aligned word.
package standard_timer_pkg;

  localparam logic [7:0] ADDR_CTRL0   = 8'h00;
  localparam logic [7:0] ADDR_CTRL1   = 8'h04;
  localparam logic [7:0] ADDR_CNT_HI  = 8'h08;
  localparam logic [7:0] ADDR_CMPA_LO = 8'h0c;
  localparam logic [7:0] ADDR_CMPA_HI = 8'h10;
  localparam logic [7:0] ADDR_CMPP    = 8'h14;
  localparam logic [7:0] ADDR_FLAGS   = 8'h18;

  localparam int CTRL0_ON_BIT = 3;
  localparam int FLAG_A_BIT   = 0;
  localparam int FLAG_P_BIT   = 1;

  localparam logic [7:0]  BYTE_RESET  = 8'h00;
  localparam logic [15:0] WORD_RESET  = 16'h0000;
  localparam logic [16:0] FULL_PERIOD = 17'h10000;

  typedef enum logic [1:0] {
    MODE_COMPARE = 2'b00,
    MODE_CAPTURE = 2'b01,
    MODE_PWM     = 2'b10,
    MODE_TIMER   = 2'b11
  } op_mode_type;

  localparam logic [1:0] PIN_KEEP      = 2'b00;
  localparam logic [1:0] PIN_LOW       = 2'b01;
  localparam logic [1:0] PIN_HIGH      = 2'b10;
  localparam logic [1:0] PIN_TOGGLE    = 2'b11;
  localparam logic [1:0] PWM_INACTIVE  = 2'b00;
  localparam logic [1:0] PWM_ACTIVE    = 2'b01;
  localparam logic [1:0] PWM_WAVE      = 2'b10;

  typedef struct packed {
    op_mode_type op_mode;
    logic [1:0]  pin_action;
    logic        out_initial_level;
    logic        out_invert;
    logic        period_duty_swap;
    logic        clear_source_sel;
  } timer_control_one_type;

  localparam timer_control_one_type CTRL1_RESET = '{
    op_mode: MODE_COMPARE, pin_action: PIN_KEEP, out_initial_level: 1'b0,
    out_invert: 1'b0, period_duty_swap: 1'b0, clear_source_sel: 1'b0};

endpackage

// file: hdl/standard_timer_compare_pwm.sv
// Standard timer: 16-bit up-counter, compare A and compare P, compare
// match output, timer and edge-aligned PWM modes, APB register slave.
// Assumes timer_tick is a one-cycle pulse of the selected timer clock,
// synchronous to mclk; clk_en low freezes every flip-flop.
//
// Implementation choices: the APB slave port and the register addresses.
`timescale 1ns/100ps

module standard_timer_compare_pwm
  import standard_timer_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  input  wire logic        timer_tick,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             timer_output_pin,
  output logic             timer_output_oe,
  output logic             match_a_flag,
  output logic             match_p_flag,
  output logic             timer_request
);

  timer_control_one_type ctrl1_reg;
  logic                  counter_on_reg;
  logic [15:0]           count_reg;
  logic [15:0]           count_next;
  logic [15:0]           compare_a_value_reg;
  logic [7:0]            compare_p_reg;
  logic                  match_a_reg;
  logic                  match_p_reg;
  logic                  pin_state_reg;
  logic [31:0]           prdata_reg;
  logic                  out_reg;
  logic                  oe_reg;

  logic                  access;
  logic                  wr_en;
  logic                  mapped;
  logic                  on_rise;
  logic                  step;
  logic [16:0]           inc;
  logic                  a_hit;
  logic                  p_hit;
  logic                  is_pwm;
  logic                  clear_by_a;
  logic                  count_clear;
  logic                  a_set;
  logic                  p_set;
  logic                  clr_a;
  logic                  clr_p;
  logic [16:0]           duty;
  logic                  pwm_active;
  logic                  pwm_level;

  // Bus decode; zero wait states while clk_en is high
  assign access  = psel & penable;
  assign wr_en   = access & pwrite & clk_en;
  assign pready  = clk_en;
  assign mapped  = (paddr == ADDR_CTRL0) || (paddr == ADDR_CTRL1) ||
                   (paddr == ADDR_CNT_HI) || (paddr == ADDR_CMPA_LO) ||
                   (paddr == ADDR_CMPA_HI) || (paddr == ADDR_CMPP) ||
                   (paddr == ADDR_FLAGS);
  assign pslverr = access & ~mapped;
  assign prdata  = prdata_reg;

  assign on_rise = wr_en && mapped && (paddr == ADDR_CTRL0) &&
                   pwdata[CTRL0_ON_BIT] && !counter_on_reg;
  assign clr_a   = wr_en && (paddr == ADDR_FLAGS) && pwdata[FLAG_A_BIT];
  assign clr_p   = wr_en && (paddr == ADDR_FLAGS) && pwdata[FLAG_P_BIT];

  // Match detection on the value the counter is about to reach
  assign step  = clk_en && counter_on_reg && timer_tick && !on_rise;
  assign inc   = {1'b0, count_reg} + 17'h00001;
  assign p_hit = (compare_p_reg == BYTE_RESET) ? inc[16] :
                 ((inc[15:8] == compare_p_reg) && (inc[7:0] == BYTE_RESET));
  assign a_hit = (compare_a_value_reg != WORD_RESET) &&
                 (inc[15:0] == compare_a_value_reg);
  assign is_pwm     = (ctrl1_reg.op_mode == MODE_PWM);
  // PWM ignores the clear source bit and uses the swap bit instead
  assign clear_by_a = is_pwm ? ctrl1_reg.period_duty_swap
                             : ctrl1_reg.clear_source_sel;
  assign count_clear = step && (clear_by_a ? a_hit : p_hit);
  // A zero compare A wraps the counter through ffff to zero
  assign count_next  = count_clear ? WORD_RESET : inc[15:0];
  assign a_set = step && a_hit;
  assign p_set = step && p_hit && (is_pwm || !ctrl1_reg.clear_source_sel);

  // Duty in counts; a duty at or above the period never ends the active part
  assign duty = ctrl1_reg.period_duty_swap ?
                ((compare_p_reg == BYTE_RESET) ? FULL_PERIOD
                                               : {1'b0, compare_p_reg, 8'h00}) :
                {1'b0, compare_a_value_reg};
  assign pwm_active = ({1'b0, count_reg} < duty);

  always_comb begin
    case (ctrl1_reg.pin_action)
      PWM_WAVE:     pwm_level = pwm_active;
      PWM_ACTIVE:   pwm_level = 1'b1;
      default:      pwm_level = 1'b0;
    endcase
  end

  // Control and compare registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl1_reg           <= CTRL1_RESET;
      counter_on_reg      <= 1'b0;
      compare_a_value_reg <= WORD_RESET;
      compare_p_reg       <= BYTE_RESET;
    end else if (wr_en) begin
      case (paddr)
        ADDR_CTRL0:   counter_on_reg <= pwdata[CTRL0_ON_BIT];
        ADDR_CTRL1:   ctrl1_reg <= timer_control_one_type'(pwdata[7:0]);
        ADDR_CMPA_LO: compare_a_value_reg[7:0] <= pwdata[7:0];
        ADDR_CMPA_HI: compare_a_value_reg[15:8] <= pwdata[7:0];
        ADDR_CMPP:    compare_p_reg <= pwdata[7:0];
        default:      counter_on_reg <= counter_on_reg;
      endcase
    end
  end

  // Read data is captured in the setup phase and held through access
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_reg <= 32'h00000000;
    end else if (clk_en && psel && !penable) begin
      case (paddr)
        ADDR_CTRL0:   prdata_reg <= 32'(counter_on_reg) << CTRL0_ON_BIT;
        ADDR_CTRL1:   prdata_reg <= {24'h000000, ctrl1_reg};
        ADDR_CNT_HI:  prdata_reg <= {24'h000000, count_reg[15:8]};
        ADDR_CMPA_LO: prdata_reg <= {24'h000000, compare_a_value_reg[7:0]};
        ADDR_CMPA_HI: prdata_reg <= {24'h000000, compare_a_value_reg[15:8]};
        ADDR_CMPP:    prdata_reg <= {24'h000000, compare_p_reg};
        ADDR_FLAGS:   prdata_reg <= {30'h0, match_p_reg, match_a_reg};
        default:      prdata_reg <= 32'h00000000;
      endcase
    end
  end

  // Counter
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= WORD_RESET;
    end else if (clk_en) begin
      if (on_rise) begin
        count_reg <= WORD_RESET;
      end else if (step) begin
        count_reg <= count_next;
      end
    end
  end

  // Sticky match flags; a new match wins over a clear in the same cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      match_a_reg <= 1'b0;
      match_p_reg <= 1'b0;
    end else if (clk_en) begin
      match_a_reg <= a_set | (match_a_reg & ~clr_a);
      match_p_reg <= p_set | (match_p_reg & ~clr_p);
    end
  end

  // Compare mode pin state, loaded with the initial level at counter-on rise, else moved only by compare A
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_state_reg <= 1'b0;
    end else if (clk_en) begin
      if (on_rise) begin
        pin_state_reg <= ctrl1_reg.out_initial_level;
      end else if (a_set && ctrl1_reg.op_mode == MODE_COMPARE) begin
        case (ctrl1_reg.pin_action)
          PIN_LOW:    pin_state_reg <= 1'b0;
          PIN_HIGH:   pin_state_reg <= 1'b1;
          PIN_TOGGLE: pin_state_reg <= ~pin_state_reg;
          default:    pin_state_reg <= pin_state_reg;
        endcase
      end
    end
  end

  // Output pin and its enable
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      out_reg <= 1'b0;
      oe_reg  <= 1'b0;
    end else if (clk_en) begin
      case (ctrl1_reg.op_mode)
        MODE_PWM: begin
          oe_reg  <= 1'b1;
          out_reg <= (pwm_level ? ctrl1_reg.out_initial_level
                                : ~ctrl1_reg.out_initial_level)
                     ^ ctrl1_reg.out_invert;
        end
        MODE_COMPARE: begin
          oe_reg  <= 1'b1;
          out_reg <= pin_state_reg ^ ctrl1_reg.out_invert;
        end
        default: begin
          oe_reg  <= 1'b0;
          out_reg <= 1'b0;
        end
      endcase
    end
  end

  assign timer_output_pin = out_reg;
  assign timer_output_oe  = oe_reg;
  assign match_a_flag     = match_a_reg;
  assign match_p_flag     = match_p_reg;
  assign timer_request    = match_a_reg | match_p_reg;

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_counter_restart: assert property (on_rise |=> count_reg == 16'h0000)
    else $error("counter not cleared on counter-on rise");

  a_counter_freeze: assert property (
    !counter_on_reg && !on_rise |=> $stable(count_reg))
    else $error("counter moved while off");

  a_pin_initial: assert property (
    on_rise |=> pin_state_reg == $past(ctrl1_reg.out_initial_level))
    else $error("pin not loaded with initial level");

  a_pin_keep_idle: assert property (
    clk_en && !on_rise && ctrl1_reg.pin_action == PIN_KEEP
    && !wr_en |=> $stable(pin_state_reg))
    else $error("pin changed with keep action");

  a_no_p_flag: assert property (
    clk_en && !is_pwm && ctrl1_reg.clear_source_sel && !match_p_reg
    && !wr_en |=> !match_p_reg)
    else $error("P flag raised with clear source A");

  a_p_period_clear: assert property (
    step && p_hit && !clear_by_a |=> count_reg == 16'h0000 && match_p_reg)
    else $error("compare P match did not clear counter");

  a_zero_a_silent: assert property (
    compare_a_value_reg == 16'h0000 && !match_a_reg && !wr_en
    |=> !match_a_reg)
    else $error("A flag raised with zero compare A");

  a_flag_sticky: assert property (
    match_a_reg && !clr_a |=> match_a_reg)
    else $error("A flag dropped without clear");

  a_pwm_active: assert property (
    clk_en && is_pwm && ctrl1_reg.pin_action == PWM_WAVE && pwm_active
    |=> timer_output_pin == ($past(ctrl1_reg.out_initial_level)
                             ^ $past(ctrl1_reg.out_invert)))
    else $error("PWM output not active before duty");

  a_timer_no_drive: assert property (
    clk_en && ctrl1_reg.op_mode == MODE_TIMER |=> !timer_output_oe)
    else $error("pin driven in timer mode");

  a_cnt_hi_read: assert property (
    clk_en && psel && !penable && paddr == ADDR_CNT_HI
    |=> prdata == {24'h000000, $past(count_reg[15:8])})
    else $error("counter high byte read wrong");

  a_cmpa_lo_write: assert property (
    wr_en && paddr == ADDR_CMPA_LO |=> compare_a_value_reg[7:0] == $past(pwdata[7:0]))
    else $error("compare A low byte not written");

  a_cmpa_hi_write: assert property (
    wr_en && paddr == ADDR_CMPA_HI |=> compare_a_value_reg[15:8] == $past(pwdata[7:0]))
    else $error("compare A high byte not written");

  a_cmpp_write: assert property (
    wr_en && paddr == ADDR_CMPP |=> compare_p_reg == $past(pwdata[7:0]))
    else $error("compare P not written");

  a_p_match_point: assert property (
    p_set |-> inc[7:0] == 8'h00)
    else $error("P match off a multiple of 256");

  a_overflow_clear: assert property (
    step && compare_p_reg == 8'h00 && !clear_by_a && count_reg == 16'hffff
    |=> count_reg == 16'h0000 && match_p_reg)
    else $error("overflow did not clear counter");

  a_count_step: assert property (
    step && !count_clear |=> count_reg == $past(count_reg) + 16'h0001)
    else $error("counter did not step by one");

  a_count_hold: assert property (
    !step && !on_rise |=> $stable(count_reg))
    else $error("counter moved without a tick");

  a_clear_by_a: assert property (
    !is_pwm && ctrl1_reg.clear_source_sel && step && a_hit |=> count_reg == 16'h0000)
    else $error("compare A match did not clear counter");

  a_pwm_a_flag: assert property (
    is_pwm && step && a_hit |=> match_a_reg)
    else $error("PWM A match did not raise A flag");

  a_pwm_p_flag: assert property (
    is_pwm && step && p_hit |=> match_p_reg)
    else $error("PWM P match did not raise P flag");

  a_pin_only_a: assert property (
    clk_en && !on_rise && !a_set |=> $stable(pin_state_reg))
    else $error("pin state moved without A match");

  a_pin_high: assert property (
    a_set && ctrl1_reg.op_mode == MODE_COMPARE && ctrl1_reg.pin_action == PIN_HIGH
    |=> pin_state_reg)
    else $error("high action did not drive pin high");

  a_pin_low: assert property (
    a_set && ctrl1_reg.op_mode == MODE_COMPARE && ctrl1_reg.pin_action == PIN_LOW
    |=> !pin_state_reg)
    else $error("low action did not drive pin low");

  a_pin_toggle: assert property (
    a_set && ctrl1_reg.op_mode == MODE_COMPARE && ctrl1_reg.pin_action == PIN_TOGGLE
    |=> pin_state_reg != $past(pin_state_reg))
    else $error("toggle action did not toggle pin");

  a_swap_period: assert property (
    is_pwm && ctrl1_reg.period_duty_swap && step && a_hit |=> count_reg == 16'h0000)
    else $error("swapped PWM period not set by compare A");

  a_pwm_no_clr: assert property (
    is_pwm && !ctrl1_reg.period_duty_swap && step && a_hit && !p_hit
    |=> count_reg != 16'h0000)
    else $error("PWM cleared by compare A without swap");

  a_pwm_inactive: assert property (
    clk_en && is_pwm && ctrl1_reg.pin_action == PWM_WAVE && !pwm_active
    |=> timer_output_pin == ($past(ctrl1_reg.out_initial_level)
                             ~^ $past(ctrl1_reg.out_invert)))
    else $error("PWM output active after duty");

  a_pwm_forced: assert property (
    clk_en && is_pwm && ctrl1_reg.pin_action == PWM_ACTIVE
    |=> timer_output_pin == ($past(ctrl1_reg.out_initial_level)
                             ^ $past(ctrl1_reg.out_invert)))
    else $error("forced active PWM level wrong");

  c_pwm_a_match:  cover property (is_pwm && a_set);
  c_p_clear:      cover property (count_clear && !clear_by_a);
  c_a_clear:      cover property (count_clear && clear_by_a && !is_pwm);
  c_flag_race:    cover property (a_set && clr_a);
  c_pwm_p_match:  cover property (is_pwm && p_set);

endmodule

// file: testbench/pin_load_model.sv
// Load on the timer output pin: counts high cycles inside a window.
// Assumes the pin has a pull-down when the block does not drive it.
`timescale 1ns/100ps

module pin_load_model (
  input  wire logic        mclk,
  input  wire logic        pin,
  input  wire logic        oe,
  input  wire logic        win,
  output logic      [31:0] high_cnt
);
  logic line;

  // Undriven pin falls to the pull-down level
  assign line = oe ? pin : 1'b0;

  always_ff @(posedge mclk) begin
    if (!win) begin
      high_cnt <= 32'h0;
    end else if (line) begin
      high_cnt <= high_cnt + 32'h1;
    end
  end
endmodule

// file: testbench/standard_timer_compare_pwm_tb.sv
// Self-checking bench for the standard timer block over APB.
// Assumes an APB slave that may stall while clk_en is low, and a pulled-down output pin.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin err_total++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end

module standard_timer_compare_pwm_tb;
  import standard_timer_pkg::*;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic        clk_en = 1'b1;
  logic        timer_tick = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rdata, high_cnt;
  logic        pready, pslverr, rerr, pin, oe, fa, fp, req;
  logic        win = 1'b0;
  int          err_total = 0;
  int          compares = 0;
  int          cyc = 0;

  always #2 mclk = ~mclk;

  standard_timer_compare_pwm dut (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en),
    .timer_tick(timer_tick), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_output_pin(pin), .timer_output_oe(oe),
    .match_a_flag(fa), .match_p_flag(fp), .timer_request(req));

  pin_load_model load (.mclk(mclk), .pin(pin), .oe(oe), .win(win), .high_cnt(high_cnt));

  task print_verdict;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 95000) begin
      err_total++;
      print_verdict();
    end
  end

  task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask

  task rd(input logic [7:0] a);
    apb(a, 1'b0, 32'h0);
  endtask

  task settle;
    repeat (2) @(posedge mclk);
    #1;
  endtask

  task ticks(input int n);
    repeat (n) begin
      @(posedge mclk);
      timer_tick <= 1'b1;
    end
    @(posedge mclk);
    timer_tick <= 1'b0;
    settle();
  endtask

  task setup(input logic [7:0] c1, input logic [15:0] a, input logic [7:0] p);
    wr(ADDR_CMPA_LO, {24'h0, a[7:0]});
    wr(ADDR_CMPA_HI, {24'h0, a[15:8]});
    wr(ADDR_CMPP, {24'h0, p});
    wr(ADDR_CTRL1, {24'h0, c1});
    wr(ADDR_CTRL0, 32'h0);
    wr(ADDR_CTRL0, 32'h1 << CTRL0_ON_BIT);
    wr(ADDR_FLAGS, 32'h3);
    settle();
  endtask

  task pwm(input logic [7:0] c1, input logic [15:0] a, input logic [7:0] p,
           input int per, input int hi);
    setup(c1, a, p);
    @(posedge mclk);
    timer_tick <= 1'b1;
    repeat (20) @(posedge mclk);
    win <= 1'b1;
    repeat (2 * per) @(posedge mclk);
    win <= 1'b0;
    timer_tick <= 1'b0;
    #1;
    `CHK("pwm_high", 2 * hi, high_cnt)
  endtask

  logic [7:0] exp_pin;

  initial begin
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      rd(ADDR_CTRL1 + 8'(4 * i));
      `CHK("reset_value", 32'h0, rdata)
    end
    wr(ADDR_CNT_HI, 32'h55);
    rd(ADDR_CNT_HI);
    `CHK("cnt_hi_ro", 32'h0, rdata)
    rd(8'h1c);
    `CHK("unmapped_err", 1'b1, rerr)
    wr(ADDR_CMPA_LO, 32'ha5);
    wr(ADDR_CMPA_HI, 32'h3c);
    rd(ADDR_CMPA_LO);
    `CHK("cmpa_lo", 32'ha5, rdata)
    rd(ADDR_CMPA_HI);
    `CHK("cmpa_hi", 32'h3c, rdata)
    // Every pin action code from both initial levels, cleared by compare A
    for (int i = 0; i < 8; i++) begin
      setup({MODE_COMPARE, 2'(i % 4), 1'(i / 4), 3'b001}, 16'h0002, 8'h00);
      `CHK("pin_initial", 1'(i / 4), pin)
      ticks(1);
      `CHK("flag_a_early", 1'b0, fa)
      ticks(1);
      exp_pin = {1'(i / 4), 1'b0, 1'b1, ~1'(i / 4)} >> (3 - i % 4);
      `CHK("flag_a", 1'b1, fa)
      `CHK("flag_p", 1'b0, fp)
      `CHK("pin_action", exp_pin[0], pin)
      `CHK("request", 1'b1, req)
    end
    // Clear by compare P at 256 ticks, pin only moved by A
    setup({MODE_COMPARE, PIN_TOGGLE, 4'b0000}, 16'h0005, 8'h01);
    ticks(255);
    `CHK("p_early", 1'b0, fp)
    `CHK("pin_a", 1'b1, pin)
    ticks(1);
    `CHK("p_match", 1'b1, fp)
    `CHK("a_kept", 1'b1, fa)
    `CHK("pin_p", 1'b1, pin)
    rd(ADDR_CNT_HI);
    `CHK("cleared", 32'h0, rdata)
    // P below A with clear by A: no P flag
    setup({MODE_COMPARE, PIN_KEEP, 4'b0001}, 16'h012c, 8'h01);
    ticks(300);
    `CHK("a_only", 2'b01, {fp, fa})
    // Free run, freeze and overflow
    setup({MODE_TIMER, PIN_KEEP, 4'b0000}, 16'h0000, 8'h00);
    ticks(512);
    wr(ADDR_CTRL0, 32'h0);
    ticks(256);
    rd(ADDR_CNT_HI);
    `CHK("frozen", 32'h2, rdata)
    wr(ADDR_CTRL0, 32'h1 << CTRL0_ON_BIT);
    rd(ADDR_CNT_HI);
    `CHK("restart", 32'h0, rdata)
    // Clock enable low: ticks must not move the counter
    @(posedge mclk);
    clk_en <= 1'b0;
    ticks(256);
    @(posedge mclk);
    clk_en <= 1'b1;
    rd(ADDR_CNT_HI);
    `CHK("clk_en_freeze", 32'h0, rdata)
    ticks(65535);
    `CHK("no_ovf", 1'b0, fp)
    ticks(1);
    `CHK("ovf", 2'b10, {fp, fa})
    setup({MODE_TIMER, PIN_TOGGLE, 4'b0001}, 16'h0002, 8'h00);
    ticks(2);
    `CHK("timer_mode", 2'b01, {oe, fa})
    pwm({MODE_PWM, PWM_WAVE, 4'b1001}, 16'd64, 8'h01, 256, 64);
    `CHK("pwm_flags", 2'b11, {fp, fa})
    pwm({MODE_PWM, PWM_WAVE, 4'b1100}, 16'd64, 8'h01, 256, 192);
    pwm({MODE_PWM, PWM_WAVE, 4'b0000}, 16'd64, 8'h01, 256, 192);
    pwm({MODE_PWM, PWM_WAVE, 4'b1000}, 16'd256, 8'h01, 256, 256);
    pwm({MODE_PWM, PWM_WAVE, 4'b1010}, 16'd300, 8'h01, 300, 256);
    pwm({MODE_PWM, PWM_WAVE, 4'b1010}, 16'd200, 8'h01, 200, 200);
    pwm({MODE_PWM, PWM_ACTIVE, 4'b1000}, 16'd64, 8'h01, 256, 256);
    pwm({MODE_PWM, PWM_INACTIVE, 4'b1000}, 16'd64, 8'h01, 256, 0);
    print_verdict();
  end
endmodule
